//--- ttc_top.sv
// Purpose: Control, status and latch loading of a three-channel timer
// Assumes: Bus strobe enable_in is a one-cycle access pulse on mclk_in
// Notes: Counter reads return the high byte and stage the low byte
//
// How it works
// - Control bit 1 picks external or system clock
// - Sixteen-bit mode times out after N+1 ticks
// - Dual-byte mode times out after (L+1)(M+1)
// - Bit 6 masks timer flag from interrupt
// - Bit 7 gates waveform onto output pin
// - Internal reset bit holds all timers preset
// - Control2 bit 0 steers shared write address
// - Control3 bit 0 adds divide-by-eight prescaler
// - Status holds three flags plus composite bit
// - Composite is OR of masked flags
// - Any timer reset clears every flag
// - Counter read clears flag after status read
// - Latch write with bit 4 clear clears flag
// - Initialization copies latch into counter
// - One high-byte buffer at three addresses
// - Latch write loads low byte and buffer
// - External reset sets latches to maximum
// - Internal reset leaves latches unchanged
// - Internal reset presets, stops, lowers, clears
// - Control2 own address, 1 and 3 shared
// - Bits 3 and 5 zero select continuous mode
`timescale 1ns/100ps
`default_nettype none
module ttc_top (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic enable_in,
   input wire logic rw_in,
   input wire logic [2:0] rs_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   input wire logic [2:0] external_clock_input_n_in,
   input wire logic [2:0] gate_n_in,
   output logic [2:0] timer_waveform_out,
   output logic irq_n_out
);
   import ttc_pkg::*;
   logic [7:0] ctrl_ff [3];
   logic [7:0] nxt_ctrl [3];
   logic [15:0] latch_ff [3];
   logic [15:0] nxt_latch [3];
   logic [7:0] msb_buf_ff, nxt_msb_buf, lsb_rd_ff, nxt_lsb_rd, rdata_ff, nxt_rdata;
   logic [2:0] flag_ff, nxt_flag, seen_ff, nxt_seen;
   logic [2:0] init, dual, cksrc, timeout, wave, mask;
   logic [47:0] latch_bus, count_bus;
   logic wr, rd, hold, composite;
   logic [1:0] tsel;
   ttc_tick_if tk ();

   function automatic logic [1:0] timer_of(input logic [2:0] a);
      return 2'(a[2:1] - 2'h1);
   endfunction
   ////////////////////////////////////////////////////////////////////
   assign hold = ctrl_ff[0][BIT_LOW_SELECT];
   assign wr = enable_in & ~rw_in;
   assign rd = enable_in & rw_in;
   assign tsel = timer_of(rs_in);
   always_comb begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
         cksrc[i] = ctrl_ff[i][BIT_CLOCK_SOURCE];
         dual[i] = ctrl_ff[i][BIT_DUAL_BYTE];
         mask[i] = ctrl_ff[i][BIT_IRQ_MASK];
         latch_bus[i*16 +: 16] = latch_ff[i];
         timer_waveform_out[i] = wave[i] & ctrl_ff[i][BIT_OUTPUT_EN];
      end
   end
   assign composite = |(flag_ff & mask);
   assign irq_n_out = ~composite;
   ////////////////////////////////////////////////////////////////////
   ttc_tick_gen u_tick (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .ext_clk_n_in(external_clock_input_n_in),
      .gate_n_in(gate_n_in),
      .clock_source_select_in(cksrc),
      .timer3_prescale_select_in(ctrl_ff[2][BIT_LOW_SELECT]),
      .hold_in(hold),
      .tk(tk.src)
   );
   ttc_counters u_cnt (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .tk(tk.dst),
      .hold_in(hold),
      .init_in(init),
      .dual_in(dual),
      .latch_in(latch_bus),
      .count_out(count_bus),
      .timeout_out(timeout),
      .wave_out(wave)
   );
   ////////////////////////////////////////////////////////////////////
   // Register writes and latch loading
   always_comb begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
         nxt_ctrl[i] = ctrl_ff[i];
         nxt_latch[i] = latch_ff[i];
      end
      nxt_msb_buf = msb_buf_ff;
      init = 3'h0;
      if (wr) begin
         unique case (rs_in)
            ADDR_SHARED_CTRL: begin
               if (ctrl_ff[1][BIT_LOW_SELECT]) begin
                  nxt_ctrl[0] = data_in;
               end else begin
                  nxt_ctrl[2] = data_in;
               end
            end
            ADDR_CTRL2_STATUS: nxt_ctrl[1] = data_in;
            ADDR_T1, ADDR_T2, ADDR_T3: nxt_msb_buf = data_in;
            ADDR_T1_LSB, ADDR_T2_LSB, ADDR_T3_LSB: begin
               nxt_latch[tsel] = {msb_buf_ff, data_in};
               // Any mode with mode bit b clear reloads on write
               if (!ctrl_ff[tsel][BIT_MODE_B]) begin
                  init[tsel] = 1'b1;
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Flags: a time-out in the clearing cycle wins over the clear
   always_comb begin
      nxt_flag = flag_ff;
      nxt_seen = seen_ff;
      nxt_rdata = rdata_ff;
      nxt_lsb_rd = lsb_rd_ff;
      if (rd) begin
         unique case (rs_in)
            ADDR_SHARED_CTRL: nxt_rdata = 8'h00;
            ADDR_CTRL2_STATUS: begin
               nxt_rdata = {composite, 4'h0, flag_ff};
               nxt_seen = seen_ff | flag_ff;
            end
            ADDR_T1, ADDR_T2, ADDR_T3: begin
               nxt_rdata = count_bus[tsel*16 + 8 +: 8];
               nxt_lsb_rd = count_bus[tsel*16 +: 8];
               if (seen_ff[tsel]) begin
                  nxt_flag[tsel] = 1'b0;
               end
            end
            ADDR_T1_LSB, ADDR_T2_LSB, ADDR_T3_LSB: nxt_rdata = lsb_rd_ff;
         endcase
      end
      nxt_flag = nxt_flag & ~init;
      nxt_flag = nxt_flag | timeout;
      if (hold) begin
         nxt_flag = 3'h0;
      end
      nxt_seen = nxt_seen & nxt_flag;
   end
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_ff[0] <= CTRL1_RESET;
         ctrl_ff[1] <= CTRL_RESET;
         ctrl_ff[2] <= CTRL_RESET;
         for (int i = 0; i < NUM_TIMERS; i++) begin
            latch_ff[i] <= LATCH_RESET;
         end
         msb_buf_ff <= 8'h00;
         lsb_rd_ff <= 8'h00;
         rdata_ff <= 8'h00;
         flag_ff <= 3'h0;
         seen_ff <= 3'h0;
      end else begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            ctrl_ff[i] <= nxt_ctrl[i];
            latch_ff[i] <= nxt_latch[i];
         end
         msb_buf_ff <= nxt_msb_buf;
         lsb_rd_ff <= nxt_lsb_rd;
         rdata_ff <= nxt_rdata;
         flag_ff <= nxt_flag;
         seen_ff <= nxt_seen;
      end
   end
   assign data_out = rdata_ff;
endmodule
`default_nettype wire

//--- ttc_pkg.sv
// Purpose: Shared constants for the triple timer control and status block
// Assumes: 8-bit processor bus with three register-select inputs
// Notes: Register selects are the byte address of the location
package ttc_pkg;
   localparam int NUM_TIMERS = 3;
   localparam int CNT_W = 16;
   localparam logic [2:0] ADDR_SHARED_CTRL = 3'h0;
   localparam logic [2:0] ADDR_CTRL2_STATUS = 3'h1;
   localparam logic [2:0] ADDR_T1 = 3'h2;
   localparam logic [2:0] ADDR_T1_LSB = 3'h3;
   localparam logic [2:0] ADDR_T2 = 3'h4;
   localparam logic [2:0] ADDR_T2_LSB = 3'h5;
   localparam logic [2:0] ADDR_T3 = 3'h6;
   localparam logic [2:0] ADDR_T3_LSB = 3'h7;
   localparam int BIT_LOW_SELECT = 0;
   localparam int BIT_CLOCK_SOURCE = 1;
   localparam int BIT_DUAL_BYTE = 2;
   localparam int BIT_MODE_A = 3;
   localparam int BIT_MODE_B = 4;
   localparam int BIT_MODE_C = 5;
   localparam int BIT_IRQ_MASK = 6;
   localparam int BIT_OUTPUT_EN = 7;
   localparam int BIT_COMPOSITE = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h01;
   localparam logic [15:0] LATCH_RESET = 16'hFFFF;
   localparam logic [2:0] PRESCALE_DIV = 3'h7;
   localparam int SYNC_STAGES = 2;
endpackage

//--- ttc_tick_if.sv
// Purpose: Carries count ticks and gate levels between timer modules
// Assumes: One clock domain
// Notes: None
`timescale 1ns/100ps
`default_nettype none
interface ttc_tick_if;
   logic [2:0] tick;
   logic [2:0] gate_low;
   modport src (output tick, output gate_low);
   modport dst (input tick, input gate_low);
endinterface
`default_nettype wire

//--- ttc_tick_gen.sv
// Purpose: Synchronises external clocks and gates, makes count ticks
// Assumes: Pin inputs are asynchronous to mclk_in
// Notes: External clocks count on a recognised falling edge
`timescale 1ns/100ps
`default_nettype none
module ttc_tick_gen (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [2:0] ext_clk_n_in,
   input wire logic [2:0] gate_n_in,
   input wire logic [2:0] clock_source_select_in,
   input wire logic timer3_prescale_select_in,
   input wire logic hold_in,
   ttc_tick_if.src tk
);
   import ttc_pkg::*;
   logic [2:0] s1_ff, s2_ff, s3_ff, g1_ff, g2_ff;
   logic [2:0] nxt_s1, nxt_s2, nxt_s3, nxt_g1, nxt_g2;
   logic [2:0] pre_ff, nxt_pre;
   logic [2:0] raw;
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s1 = ext_clk_n_in;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      nxt_g1 = gate_n_in;
      nxt_g2 = g1_ff;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         raw[i] = clock_source_select_in[i] ? 1'b1 : (s3_ff[i] & ~s2_ff[i]);
      end
      nxt_pre = pre_ff;
      // Prescaler sits between clock selection and counter 3
      if (hold_in) begin
         nxt_pre = 3'h0;
      end else if (raw[2]) begin
         nxt_pre = pre_ff + 3'h1;
      end
      tk.tick = raw;
      if (timer3_prescale_select_in) begin
         tk.tick[2] = raw[2] & (pre_ff == PRESCALE_DIV);
      end
      tk.gate_low = ~g2_ff;
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_ff <= 3'h7;
         s2_ff <= 3'h7;
         s3_ff <= 3'h7;
         g1_ff <= 3'h7;
         g2_ff <= 3'h7;
         pre_ff <= 3'h0;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
         g1_ff <= nxt_g1;
         g2_ff <= nxt_g2;
         pre_ff <= nxt_pre;
      end
   end
endmodule
`default_nettype wire

//--- ttc_counters.sv
// Purpose: Three 16-bit down counters with time-out and waveform
// Assumes: Ticks and gates arrive already synchronised
// Notes: Only continuous-mode waveforms are modelled
`timescale 1ns/100ps
`default_nettype none
module ttc_counters (
   input wire logic mclk_in,
   input wire logic resetn_in,
   ttc_tick_if.dst tk,
   input wire logic hold_in,
   input wire logic [2:0] init_in,
   input wire logic [2:0] dual_in,
   input wire logic [47:0] latch_in,
   output logic [47:0] count_out,
   output logic [2:0] timeout_out,
   output logic [2:0] wave_out
);
   import ttc_pkg::*;
   logic [15:0] cnt_ff [3];
   logic [15:0] nxt_cnt [3];
   logic [2:0] wave_ff, nxt_wave, gprev_ff, nxt_gprev;
   logic [15:0] lat;
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_wave = wave_ff;
      nxt_gprev = tk.gate_low;
      timeout_out = 3'h0;
      lat = 16'h0000;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         lat = latch_in[i*16 +: 16];
         nxt_cnt[i] = cnt_ff[i];
         count_out[i*16 +: 16] = cnt_ff[i];
         if (hold_in) begin
            nxt_cnt[i] = lat;
            nxt_wave[i] = 1'b0;
         end else if (init_in[i] || (tk.gate_low[i] && !gprev_ff[i])) begin
            nxt_cnt[i] = lat;
            nxt_wave[i] = 1'b0;
         end else if (tk.tick[i] && tk.gate_low[i]) begin
            if (!dual_in[i]) begin
               if (cnt_ff[i] == 16'h0000) begin
                  nxt_cnt[i] = lat;
                  timeout_out[i] = 1'b1;
                  nxt_wave[i] = ~wave_ff[i];
               end else begin
                  nxt_cnt[i] = cnt_ff[i] - 16'h0001;
               end
            end else if (cnt_ff[i] == 16'h0000) begin
               nxt_cnt[i] = lat;
               timeout_out[i] = 1'b1;
               nxt_wave[i] = (lat[7:0] == 8'h00) ? ~wave_ff[i] : 1'b0;
            end else if (cnt_ff[i][7:0] == 8'h00) begin
               nxt_cnt[i] = {cnt_ff[i][15:8] - 8'h01, lat[7:0]};
               if (cnt_ff[i][15:8] == 8'h01 && lat[7:0] != 8'h00) begin
                  nxt_wave[i] = 1'b1;
               end
            end else begin
               nxt_cnt[i] = {cnt_ff[i][15:8], cnt_ff[i][7:0] - 8'h01};
            end
         end
      end
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            cnt_ff[i] <= LATCH_RESET;
         end
         wave_ff <= 3'h0;
         gprev_ff <= 3'h0;
      end else begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            cnt_ff[i] <= nxt_cnt[i];
         end
         wave_ff <= nxt_wave;
         gprev_ff <= nxt_gprev;
      end
   end
   assign wave_out = wave_ff;
endmodule
`default_nettype wire

//--- ttc_monitor.sv
// Purpose: Port-level checks of the timer control block
// Assumes: Shadow control bits follow bus writes
// Notes: Shadow vectors hold timer 1 in bit 0
`timescale 1ns/100ps
`default_nettype none
module ttc_monitor (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic enable_in,
   input wire logic rw_in,
   input wire logic [2:0] rs_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic [2:0] timer_waveform_out,
   input wire logic irq_n_out
);
   logic sel_ff, nxt_sel, irst_ff, nxt_irst, wr;
   logic [2:0] oe_ff, nxt_oe, msk_ff, nxt_msk;
   logic [1:0] held_ff, nxt_held;
   always_comb begin
      wr = enable_in && !rw_in;
      {nxt_sel, nxt_irst, nxt_oe, nxt_msk} = {sel_ff, irst_ff, oe_ff, msk_ff};
      if (wr && rs_in == 3'h1) begin
         nxt_sel = data_in[0];
         {nxt_oe[1], nxt_msk[1]} = data_in[7:6];
      end
      if (wr && rs_in == 3'h0 && sel_ff) begin
         nxt_irst = data_in[0];
         {nxt_oe[0], nxt_msk[0]} = data_in[7:6];
      end
      if (wr && rs_in == 3'h0 && !sel_ff)
         {nxt_oe[2], nxt_msk[2]} = data_in[7:6];
      // Saturating count of cycles spent under internal reset
      nxt_held = !irst_ff ? 2'h0 : (held_ff == 2'h3 ? held_ff : held_ff + 2'h1);
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {sel_ff, irst_ff, oe_ff, msk_ff, held_ff} <= {1'b0, 1'b1, 3'h0, 3'h0, 2'h0};
      end else begin
         {sel_ff, irst_ff, oe_ff, msk_ff, held_ff} <= {nxt_sel, nxt_irst, nxt_oe, nxt_msk, nxt_held};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   status_pad_a: assert property (
      enable_in && rw_in && rs_in == 3'h1 |=> data_out[6:3] == 4'h0)
      else $error("Status unused bits not zero");
   composite_irq_a: assert property (
      enable_in && rw_in && rs_in == 3'h1 |=> data_out[7] == !$past(irq_n_out))
      else $error("Composite bit disagrees with interrupt");
   shared_read_a: assert property (
      enable_in && rw_in && rs_in == 3'h0 |=> data_out == 8'h00)
      else $error("Shared control read not zero");
   read_hold_a: assert property (
      !$past(enable_in && rw_in) |-> $stable(data_out))
      else $error("Read data changed without a read");
   wave_mask_a: assert property (
      (timer_waveform_out & ~(oe_ff | $past(oe_ff))) == 3'h0)
      else $error("Masked waveform reached pin");
   irq_mask_a: assert property (
      msk_ff == 3'h0 && $past(msk_ff) == 3'h0 |-> irq_n_out)
      else $error("Interrupt with all masks off");
   held_wave_a: assert property (
      held_ff == 2'h3 |-> timer_waveform_out == 3'h0)
      else $error("Waveform high under internal reset");
   held_irq_a: assert property (
      held_ff == 2'h3 |-> irq_n_out)
      else $error("Interrupt under internal reset");
endmodule
bind ttc_top ttc_monitor u_mon (.mclk_in, .resetn_in, .enable_in, .rw_in, .rs_in, .data_in,
   .data_out, .timer_waveform_out, .irq_n_out);
`default_nettype wire

//--- ttc_cpu_model.sv
// Purpose: Processor side of the 8-bit register bus
// Assumes: One access per two cycles, driven at falling edges
// Notes: Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module ttc_cpu_model (
   input wire logic mclk_in,
   output logic enable_out,
   output logic rw_out,
   output logic [2:0] rs_out,
   output logic [7:0] data_out
);
   initial begin
      {enable_out, rw_out, rs_out, data_out} = 13'h0;
   end
   task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      {enable_out, rw_out, rs_out, data_out} = {1'b1, rd, a, d};
      @(negedge mclk_in);
      enable_out = 1'b0;
      // Stale address and data must not look valid
      rs_out = ~a;
      data_out = ~d;
   endtask
   // High byte to the staging buffer always goes first
   task automatic load(input logic [2:0] buf_a, input logic [2:0] lo_a, input logic [15:0] v);
      access(1'b0, buf_a, v[15:8]);
      access(1'b0, lo_a, v[7:0]);
   endtask
endmodule
`default_nettype wire

//--- triple_timer_control_status_tb_top.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Gates held low so timers count when released
// Notes: Reads are queued and compared by a watcher
`timescale 1ns/100ps
`default_nettype none
module triple_timer_control_status_tb_top;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [2:0] ext_n = 3'h7;
   logic [2:0] gate_n = 3'h0;
   logic enable, rw, irq_n, rd_pend = 1'b0;
   logic [2:0] rs, wave;
   logic [7:0] din, dout;
   logic [31:0] seed = 32'd86;
   logic [15:0] exp_q[$];
   int bad_count = 0;
   int comparisons = 0;
   ttc_top uut (.mclk_in, .resetn_in, .enable_in(enable), .rw_in(rw), .rs_in(rs),
      .data_in(din), .data_out(dout), .external_clock_input_n_in(ext_n),
      .gate_n_in(gate_n), .timer_waveform_out(wave), .irq_n_out(irq_n));
   ttc_cpu_model cpu (.mclk_in, .enable_out(enable), .rw_out(rw), .rs_out(rs), .data_out(din));
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      exp_q.push_back({m, e});
      cpu.access(1'b1, a, 8'h00);
   endtask
   task automatic wait_irq(input logic lvl);
      int i;
      for (i = 0; i < 2000 && irq_n !== lvl; i++) @(negedge mclk_in);
      if (irq_n !== lvl) begin
         bad_count++;
         report_and_stop;
      end
   endtask
   // A counter read alone must not clear; status first, then counter
   task automatic clr;
      rd(3'h2, 8'h00, 8'h00);
      chk({7'h0, irq_n}, 8'h00);
      rd(3'h1, 8'hFF, 8'h81);
      rd(3'h2, 8'h00, 8'h00);
      chk({7'h0, irq_n}, 8'h01);
   endtask
   // Period between two time-outs is free of bus and pipeline latency
   task automatic measure(input int n);
      time t0;
      wait_irq(1'b0);
      t0 = $time;
      clr;
      wait_irq(1'b0);
      chk(8'(($time - t0) / 40), 8'(n));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge mclk_in) begin
      seed <= xs(seed);
      ext_n <= seed[2:0];
   end
   always @(posedge mclk_in) rd_pend <= enable && rw;
   always @(negedge mclk_in) begin
      logic [15:0] n;
      if (rd_pend && exp_q.size() > 0) begin
         n = exp_q.pop_front();
         chk(dout & n[15:8], n[7:0] & n[15:8]);
      end
   end
   initial begin
      logic [15:0] r;
      repeat (8) @(negedge mclk_in);
      resetn_in = 1'b1;
      rd(3'h1, 8'hFF, 8'h00);
      rd(3'h0, 8'hFF, 8'h00);
      rd(3'h2, 8'hFF, 8'hFF);
      rd(3'h3, 8'hFF, 8'hFF);
      $display("Test reset values done");
      cpu.access(1'b0, 3'h1, 8'h01);
      r = seed[15:0] | 16'h8000;
      cpu.load(3'h6, 3'h5, r);
      cpu.load(3'h4, 3'h3, 16'h0040);
      rd(3'h4, 8'hFF, r[15:8]);
      rd(3'h5, 8'hFF, r[7:0]);
      rd(3'h2, 8'hFF, 8'h00);
      rd(3'h3, 8'hFF, 8'h40);
      $display("Test latch loading done");
      cpu.access(1'b0, 3'h0, 8'hC2);
      measure(65);
      cpu.access(1'b0, 3'h0, 8'hC6);
      cpu.load(3'h2, 3'h3, 16'h0403);
      chk({7'h0, irq_n}, 8'h01);
      measure(20);
      $display("Test timing done");
      cpu.access(1'b0, 3'h0, 8'h86);
      chk({7'h0, irq_n}, 8'h01);
      rd(3'h1, 8'hFF, 8'h01);
      cpu.access(1'b0, 3'h0, 8'h87);
      rd(3'h1, 8'hFF, 8'h00);
      rd(3'h2, 8'hFF, 8'h04);
      rd(3'h3, 8'hFF, 8'h03);
      $display("Test mask and internal reset done");
      repeat (2) @(negedge mclk_in);
      report_and_stop;
   end
endmodule
`default_nettype wire
